// File: rtl/shs_sequencer.v
// Homing state and point/strobe handshake sequencer of a servo driver
//
// Functional notes
// [R1] Absolute setting 0 or 2: complete at power-on
// [R2] Skip setting 1: complete, load home offset
// [R3] Absolute homing saves home position to memory
// [R4] Alarm clears completion outside power-on cases
// [R5] Start clears completion; normal finish sets it
// [R6] Interrupted homing leaves completion cleared
// [R7] Tuning or response measurement clears completion
// [R8] Homing type 0 to 7 decoded
// [R9] Full-closed rejects index types with 68
// [R10] Highest point number means homing command
// [R11] Host holds points 10 ms before strobe; the host model holds them 40 clocks (1.6 us at 25 MHz)
// [R12] Busy transistor off while executing
// [R13] Host opens strobe once execution seen
// [R14] Busy stays off until strobe opens
// [R15] Busy back on signals completion
// [R16] Successful homing drives all position outputs on
// [R17] Position outputs updated within 10 ms
// [R18] Shared output picks done or decelerating
// [R19] Home preset pulses positioning done briefly
// [R20] Same handshake for every homing type
// [R21] Zero speed or ramp trips with 68
// [R22] Power-on clears completion unless an absolute or skip case
`timescale 1ns/1ps
`include "shs_defines.vh"
module shs_sequencer (
    input wire clk,
    input wire rstn,
    // Pins from the host controller, closed contact reads 1
    input wire [`SHS_POINT_W-1:0] point_select_inputs,
    input wire command_strobe_input,
    // Configuration settings
    input wire [1:0] absolute_encoder_setting,
    input wire abs_encoder_present,
    input wire homing_skip_setting,
    input wire [31:0] home_offset_value,
    input wire [2:0] homing_type_select,
    input wire control_mode_select,
    input wire [12:0] homing_speed_fast,
    input wire [12:0] homing_speed_slow,
    input wire [11:0] homing_accel_setting,
    input wire [11:0] homing_decel_setting,
    input wire homing_direction_setting,
    input wire [1:0] point_count_select,
    input wire output_signal_select,
    // Status from the motion engine, same clock
    input wire home_detected,
    input wire homing_finished,
    input wire point_op_done,
    input wire stop_request,
    input wire servo_off,
    input wire trip,
    input wire alarm_active,
    input wire tuning_done,
    input wire in_position,
    input wire decelerating,
    input wire [31:0] abs_position,
    // Commands to the motion engine
    output wire homing_run,
    output reg [2:0] homing_type_reg,
    output reg homing_dir_reg,
    output reg point_op_start_reg,
    output reg [`SHS_POINT_W-1:0] point_op_num_reg,
    output reg position_preset_reg,
    output reg [31:0] position_preset_value_reg,
    output reg nvm_write_reg,
    output reg [31:0] nvm_data_reg,
    output reg homing_trip_reg,
    output reg [7:0] error_code_reg,
    // Pins to the host and status
    output wire busy_output_on,
    output reg [`SHS_POINT_W-1:0] current_point_outputs,
    output wire shared_status_output,
    output reg homing_complete_reg
);
    // Sequencer states
    localparam ST_INIT = 3'd0;
    localparam ST_IDLE = 3'd1;
    localparam ST_HOME = 3'd2;
    localparam ST_OP = 3'd3;
    localparam ST_HOLD = 3'd4;

    localparam integer POSITIONING_DONE_OUTPUT_PULSE_INT = `SHS_POSITIONING_DONE_OUTPUT_PULSE_US * `SHS_CLK_MHZ;
    localparam [`SHS_CNT_W-1:0] POSITIONING_DONE_OUTPUT_PULSE_CYCLES =
        POSITIONING_DONE_OUTPUT_PULSE_INT[`SHS_CNT_W-1:0];

    // True for homing types that need the index pulse
    function index_type;
        input [2:0] t;
        begin
            index_type = (t == `SHS_HT_SENS_FRONT_Z) ||
                         (t == `SHS_HT_SENS_REAR_Z) ||
                         (t == `SHS_HT_LIMIT_Z) ||
                         (t == `SHS_HT_Z_ONLY);
        end
    endfunction

    // Highest point number for a point count selection
    function [`SHS_POINT_W-1:0] max_point;
        input [1:0] sel;
        begin
            case (sel)
                `SHS_PCS_8: max_point = 6'h07;
                `SHS_PCS_16: max_point = 6'h0F;
                `SHS_PCS_32: max_point = 6'h1F;
                default: max_point = 6'h3F;
            endcase
        end
    endfunction

    reg rst_meta_reg;
    reg rst_sync_reg;
    wire rst_n;
    wire [`SHS_POINT_W-1:0] points_s;
    wire strobe_s;
    reg strobe_d_reg;
    wire strobe_rise;
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [`SHS_CNT_W-1:0] positioning_done_output_cnt_reg;
    wire abs_case;
    wire power_on_case;
    wire home_cmd;
    wire type_reject;
    wire zero_setting;
    wire home_abort;
    reg homing_run_done_reg;
    reg op_ok_reg;

    // Reset released through two flops
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign rst_n = rst_sync_reg;

    // Pin inputs pass two flops before use
    shs_sync2 #(
        .WIDTH(`SHS_POINT_W + 1)
    ) u_pin_sync (
        .clk(clk),
        .rst_n(rst_n),
        .din({command_strobe_input, point_select_inputs}),
        .dout({strobe_s, points_s})
    );

    // Strobe closing edge starts an operation
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strobe_d_reg <= 1'b0;
        end else begin
            strobe_d_reg <= strobe_s;
        end
    end
    assign strobe_rise = strobe_s & ~strobe_d_reg; // [R11]

    // Power-on completion cases
    assign abs_case = abs_encoder_present &&
        ((absolute_encoder_setting == `SHS_ABS_SET_A) ||
         (absolute_encoder_setting == `SHS_ABS_SET_B)); // [R1]
    assign power_on_case = abs_case ||
        (homing_skip_setting == `SHS_SKIP_ON); // [R2]

    // Command decode and homing checks
    assign home_cmd =
        (points_s == max_point(point_count_select)); // [R10]
    assign type_reject =
        (control_mode_select == `SHS_MODE_FULL_CLOSED) &&
        index_type(homing_type_select); // [R8] [R9]
    assign zero_setting = (homing_speed_fast == 13'h0000) ||
                          (homing_speed_slow == 13'h0000) ||
                          (homing_accel_setting == 12'h000) ||
                          (homing_decel_setting == 12'h000); // [R21]
    assign home_abort = stop_request | servo_off | trip |
                        alarm_active; // [R6]

    // Next state; every homing type follows one path
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_INIT: begin
                state_next = ST_IDLE;
            end
            ST_IDLE: begin
                if (strobe_rise && !alarm_active) begin
                    if (!home_cmd) begin
                        state_next = ST_OP;
                    end else if (type_reject || zero_setting) begin
                        state_next = ST_HOLD;
                    end else begin
                        state_next = ST_HOME; // [R20]
                    end
                end
            end
            ST_HOME: begin
                if (home_abort || homing_finished) begin
                    state_next = ST_HOLD;
                end
            end
            ST_OP: begin
                if (home_abort || point_op_done) begin
                    state_next = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!strobe_s) begin
                    state_next = ST_IDLE; // [R14]
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // State register
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_INIT;
        end else begin
            state_reg <= state_next;
        end
    end

    // Busy transistor is on only while idle
    assign busy_output_on = (state_reg == ST_IDLE); // [R12] [R15]
    assign homing_run = (state_reg == ST_HOME);

    // Homing complete flag
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            homing_complete_reg <= 1'b0; // [R22]
        end else if (state_reg == ST_INIT) begin
            homing_complete_reg <= power_on_case; // [R1] [R2] [R22]
        end else if (state_reg == ST_HOME) begin
            if (home_abort) begin
                homing_complete_reg <= 1'b0; // [R6]
            end else if (homing_finished) begin
                homing_complete_reg <= 1'b1; // [R5]
            end
        end else if (state_reg == ST_IDLE && strobe_rise &&
                     home_cmd && !alarm_active) begin
            homing_complete_reg <= 1'b0; // [R5]
        end else if (tuning_done) begin
            homing_complete_reg <= 1'b0; // [R7]
        end else if (alarm_active && !power_on_case) begin
            homing_complete_reg <= 1'b0; // [R4]
        end
    end

    // Latch homing type and direction at the start of a run
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            homing_type_reg <= `SHS_HT_SENS_FRONT_Z;
            homing_dir_reg <= 1'b0;
        end else if (state_reg == ST_IDLE && strobe_rise) begin
            homing_type_reg <= homing_type_select; // [R8]
            homing_dir_reg <= homing_direction_setting;
        end
    end

    // Point operation start pulse and number
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            point_op_start_reg <= 1'b0;
            point_op_num_reg <= 6'h00;
        end else begin
            point_op_start_reg <= (state_reg == ST_IDLE) &&
                                  (state_next == ST_OP);
            if (state_reg == ST_IDLE && strobe_rise) begin
                point_op_num_reg <= points_s;
            end
        end
    end

    // Error reporting and trip request for rejected homing
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            homing_trip_reg <= 1'b0;
            error_code_reg <= `SHS_ERR_NONE;
        end else begin
            homing_trip_reg <= 1'b0;
            if (state_reg == ST_IDLE && strobe_rise && home_cmd &&
                !alarm_active && (type_reject || zero_setting)) begin
                homing_trip_reg <= 1'b1; // [R9] [R21]
                error_code_reg <= `SHS_ERR_HOMING; // [R9] [R21]
            end else if (!alarm_active && !trip &&
                         state_reg == ST_IDLE && strobe_rise) begin
                error_code_reg <= `SHS_ERR_NONE;
            end
        end
    end

    // Position preset at power-on skip and at home detection
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            position_preset_reg <= 1'b0;
            position_preset_value_reg <= 32'h0000_0000;
        end else begin
            position_preset_reg <= 1'b0;
            if (state_reg == ST_INIT &&
                homing_skip_setting == `SHS_SKIP_ON) begin
                position_preset_reg <= 1'b1; // [R2]
                position_preset_value_reg <= home_offset_value; // [R2]
            end else if (state_reg == ST_HOME && home_detected &&
                         !home_abort) begin
                position_preset_reg <= 1'b1; // [R19]
                position_preset_value_reg <= home_offset_value;
            end
        end
    end

    // Save the absolute home position on a normal finish
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nvm_write_reg <= 1'b0;
            nvm_data_reg <= 32'h0000_0000;
        end else begin
            nvm_write_reg <= 1'b0;
            if (state_reg == ST_HOME && homing_finished &&
                !home_abort && abs_case) begin
                nvm_write_reg <= 1'b1; // [R3]
                nvm_data_reg <= abs_position; // [R3]
            end
        end
    end

    // Current point outputs change as busy returns on
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            current_point_outputs <= 6'h00;
        end else if (state_reg == ST_HOLD && state_next == ST_IDLE) begin
            if (homing_complete_reg && homing_run_done_reg) begin
                current_point_outputs <= 6'h3F; // [R16] [R17]
            end else if (op_ok_reg) begin
                current_point_outputs <= point_op_num_reg; // [R17]
            end
        end
    end

    // Remember how the last operation ended
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            homing_run_done_reg <= 1'b0;
            op_ok_reg <= 1'b0;
        end else if (state_reg == ST_IDLE) begin
            homing_run_done_reg <= 1'b0;
            op_ok_reg <= 1'b0;
        end else if (state_reg == ST_HOME) begin
            homing_run_done_reg <= homing_finished && !home_abort;
        end else if (state_reg == ST_OP) begin
            op_ok_reg <= point_op_done && !home_abort;
        end
    end

    // Positioning-done pulse after a home preset
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            positioning_done_output_cnt_reg <= 12'h000;
        end else if (state_reg == ST_HOME && home_detected &&
                     !home_abort) begin
            positioning_done_output_cnt_reg <= POSITIONING_DONE_OUTPUT_PULSE_CYCLES; // [R19]
        end else if (positioning_done_output_cnt_reg != 12'h000) begin
            positioning_done_output_cnt_reg <= positioning_done_output_cnt_reg - 12'h001;
        end
    end

    // Shared output selects done or decelerating
    assign shared_status_output =
        (output_signal_select == `SHS_OUT_SEL_DECEL) ? decelerating :
        ((positioning_done_output_cnt_reg != 12'h000) | in_position); // [R18] [R19]

endmodule

// File: common/shs_defines.vh
// Constants for the servo homing sequencer
`ifndef SHS_DEFINES_VH
`define SHS_DEFINES_VH

// Clock rate in MHz
`define SHS_CLK_MHZ 25
// Positioning-done pulse length after a home preset, in microseconds
`define SHS_POSITIONING_DONE_OUTPUT_PULSE_US 100
// Width of the pulse counter
`define SHS_CNT_W 12

// Point select and current point widths
`define SHS_POINT_W 6
// Homing error code for a rejected type or a zero setting
`define SHS_ERR_HOMING 8'h44
// Error code shown while no error is pending
`define SHS_ERR_NONE 8'h00

// Absolute encoder settings that complete homing at power-on
`define SHS_ABS_SET_A 2'h0
`define SHS_ABS_SET_B 2'h2
// Homing skip setting value meaning homing not required
`define SHS_SKIP_ON 1'b1
// Control mode value for full-closed control
`define SHS_MODE_FULL_CLOSED 1'b1
// Output select value choosing the decelerating signal
`define SHS_OUT_SEL_DECEL 1'b1

// Homing types
`define SHS_HT_SENS_FRONT_Z 3'h0
`define SHS_HT_SENS_FRONT 3'h1
`define SHS_HT_SENS_REAR_Z 3'h2
`define SHS_HT_LIMIT_Z 3'h3
`define SHS_HT_LIMIT 3'h4
`define SHS_HT_Z_ONLY 3'h5
`define SHS_HT_BUMP 3'h6
`define SHS_HT_DATA_SET 3'h7

// Point count selection codes
`define SHS_PCS_8 2'h0
`define SHS_PCS_16 2'h1
`define SHS_PCS_32 2'h2
`define SHS_PCS_64 2'h3

`endif

// File: rtl/shs_sync2.v
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
module shs_sync2 #(
    parameter WIDTH = 1
) (
    input wire clk,
    input wire rst_n,
    input wire [WIDTH-1:0] din,
    output wire [WIDTH-1:0] dout
);
    genvar i;
    // One two-flop chain per bit; the first stage feeds only the second
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg meta_reg;
            reg sync_reg;
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_reg <= 1'b0;
                    sync_reg <= 1'b0;
                end else begin
                    meta_reg <= din[i];
                    sync_reg <= meta_reg;
                end
            end
            assign dout[i] = sync_reg;
        end
    endgenerate
endmodule

// File: sim/shs_checker.sv
// Port assertions for the homing sequencer
`timescale 1ns/1ps
`include "shs_defines.vh"
module shs_checker (
    input wire clk,
    input wire rstn,
    input wire command_strobe_input,
    input wire control_mode_select,
    input wire output_signal_select,
    input wire decelerating,
    input wire home_detected,
    input wire [31:0] abs_position,
    input wire homing_run,
    input wire [2:0] homing_type_reg,
    input wire position_preset_reg,
    input wire nvm_write_reg,
    input wire [31:0] nvm_data_reg,
    input wire homing_trip_reg,
    input wire [7:0] error_code_reg,
    input wire busy_output_on,
    input wire [`SHS_POINT_W-1:0] current_point_outputs,
    input wire shared_status_output,
    input wire homing_complete_reg
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // Busy output against the strobe handshake
    chk_busy_run: assert property (
        homing_run |-> !busy_output_on) else $error("busy on in run");
    chk_busy_hold: assert property (
        !busy_output_on && command_strobe_input |=> !busy_output_on)
        else $error("busy on with strobe closed");
    chk_busy_back: assert property (
        $rose(busy_output_on) |-> !command_strobe_input)
        else $error("busy back while strobe closed");
    chk_point_update: assert property (
        !$stable(current_point_outputs) |-> $rose(busy_output_on))
        else $error("points changed away from busy return");
    // Completion state
    chk_start_clear: assert property (
        $rose(homing_run) |-> !homing_complete_reg)
        else $error("complete kept at start");
    chk_set_source: assert property (
        $rose(homing_complete_reg) |-> !$past(busy_output_on))
        else $error("complete set while idle");
    // Type rejection and error code
    chk_type_allowed: assert property (
        $rose(homing_run) && control_mode_select
        |-> !(homing_type_reg inside {3'h0, 3'h2, 3'h3, 3'h5}))
        else $error("index type ran in full-closed");
    chk_trip_code: assert property (
        homing_trip_reg |-> ##[0:1] error_code_reg == `SHS_ERR_HOMING)
        else $error("wrong homing error code");
    // Shared output, preset and stored home
    chk_shared_sel: assert property (
        output_signal_select |-> shared_status_output == decelerating)
        else $error("shared output not decelerating");
    chk_home_preset: assert property (
        home_detected && homing_run |-> ##[1:2] position_preset_reg)
        else $error("no preset at home");
    chk_nvm_data: assert property (
        nvm_write_reg |-> nvm_data_reg == abs_position)
        else $error("stored home differs");
    cov_complete: cover property ($rose(homing_complete_reg));
    cov_trip: cover property (homing_trip_reg);
    cov_nvm: cover property (nvm_write_reg);
endmodule
bind shs_sequencer shs_checker u_chk (.*);

// File: sim/shs_host_model.sv
// Host controller model driving point code and strobe
`timescale 1ns/1ps
module shs_host_model #(
    parameter HOLD_CYC = 40
) (
    clk,
    busy_output_on,
    point_select_inputs,
    command_strobe_input
);
    input wire clk;
    input wire busy_output_on;
    output reg [5:0] point_select_inputs;
    output reg command_strobe_input;
    integer n;
    // Contacts open at power-on
    initial begin
        point_select_inputs = 6'h00;
        command_strobe_input = 1'h0;
    end
    // Same sequence for any point or homing type
    task press(input [5:0] code);
        begin
            @(negedge clk);
            point_select_inputs = code;
            repeat (HOLD_CYC) @(negedge clk);
            command_strobe_input = 1'h1;
            n = 0;
            while (busy_output_on !== 1'h0 && n < 20) begin
                @(negedge clk);
                n = n + 1;
            end
        end
    endtask
    // Open strobe once running, then wait before reading points
    task release_strobe;
        begin
            command_strobe_input = 1'h0;
            n = 0;
            while (busy_output_on !== 1'h1 && n < 20) begin
                @(negedge clk);
                n = n + 1;
            end
            repeat (HOLD_CYC) @(negedge clk);
        end
    endtask
endmodule

// File: sim/tb.sv
// Self-checking bench for the homing sequencer
`timescale 1ns/1ps
`include "shs_defines.vh"
module tb;
    reg clk = 1'h0;
    reg rstn = 1'h0;
    reg [1:0] absolute_encoder_setting = 2'h0;
    reg [1:0] point_count_select = 2'h0;
    reg [2:0] homing_type_select = 3'h0;
    reg abs_encoder_present = 1'h0;
    reg homing_skip_setting = 1'h0;
    reg control_mode_select = 1'h0;
    reg output_signal_select = 1'h1;
    reg decelerating = 1'h0;
    reg homing_direction_setting = 1'h0;
    reg in_position = 1'h0;
    reg [31:0] home_offset_value = 32'h0000_1234;
    reg [31:0] abs_position = 32'h0001_5678;
    reg [12:0] homing_speed_fast = 13'h0064;
    reg [12:0] homing_speed_slow = 13'h0010;
    reg [11:0] homing_accel_setting = 12'h100;
    reg [11:0] homing_decel_setting = 12'h100;
    reg [3:0] ev = 4'h0;
    reg [3:0] ab = 4'h0;
    reg [7:0] idx_types = 8'h2D;
    integer i, compares = 0, mismatches = 0, cycles = 0;
    wire home_detected, homing_finished, point_op_done, tuning_done;
    wire stop_request, servo_off, trip, alarm_active;
    wire [5:0] point_select_inputs, point_op_num_reg, current_point_outputs;
    wire command_strobe_input, homing_run, homing_dir_reg;
    wire point_op_start_reg, position_preset_reg, nvm_write_reg;
    wire homing_trip_reg, busy_output_on, shared_status_output;
    wire homing_complete_reg;
    wire [2:0] homing_type_reg;
    wire [31:0] position_preset_value_reg, nvm_data_reg;
    wire [7:0] error_code_reg;
    // Motion events and abort causes as one-hot groups
    assign {tuning_done, point_op_done, homing_finished, home_detected} = ev;
    assign {alarm_active, trip, servo_off, stop_request} = ab;
    shs_sequencer u_dut (.*);
    shs_host_model #(.HOLD_CYC(40)) u_host (.*);
    always #20 clk = ~clk;
    // Cycle ceiling against a hung handshake
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            report_and_stop;
        end
    end
    task check(input string nm, input [31:0] exp, input [31:0] got);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("unexpected %s exp %h got %h", nm, exp, got);
            end
        end
    endtask
    task do_reset;
        begin
            rstn = 1'h0;
            repeat (16) @(negedge clk);
            rstn = 1'h1;
            repeat (6) @(negedge clk);
        end
    endtask
    // One homing command, accepted or refused
    task home(input [2:0] t, input rej);
        reg [5:0] prev;
        begin
            prev = current_point_outputs;
            homing_type_select = t;
            u_host.press((6'h08 << point_count_select) - 6'h01);
            if (rej) begin
                check("error", `SHS_ERR_HOMING, error_code_reg);
                check("run", 1'h0, homing_run);
            end else begin
                check("complete", 1'h0, homing_complete_reg);
                check("error", `SHS_ERR_NONE, error_code_reg);
                ev = 4'h1;
                @(negedge clk);
                check("pulse", 1'h1, position_preset_reg);
                check("positioning_done_output", 1'h1, shared_status_output);
                ev = 4'h2;
                @(negedge clk);
                ev = 4'h0;
                check("complete", 1'h1, homing_complete_reg);
                check("preset", home_offset_value,
                    position_preset_value_reg);
            end
            check("busy", 1'h0, busy_output_on);
            u_host.release_strobe;
            check("busy", 1'h1, busy_output_on);
            check("points", rej ? prev : 6'h3F,
                current_point_outputs);
        end
    endtask
    task report_and_stop;
        begin
            $display("compares %0d mismatches %0d", compares, mismatches);
            if (mismatches == 0 && compares > 0) begin
                $display("[ PASS ]");
            end else begin
                $display("[ FAIL ]");
            end
            $finish;
        end
    endtask
    // Main sequence
    initial begin
        do_reset;
        check("complete", 1'h0, homing_complete_reg);
        decelerating = 1'h1;
        @(negedge clk);
        check("shared", 1'h1, shared_status_output);
        output_signal_select = 1'h0;
        @(negedge clk);
        check("shared", 1'h0, shared_status_output);
        // Ordinary point move below the homing code
        u_host.press(6'h05);
        check("run", 1'h0, homing_run);
        check("start", 1'h1, point_op_start_reg);
        check("number", 6'h05, point_op_num_reg);
        ev = 4'h4;
        @(negedge clk);
        ev = 4'h0;
        u_host.release_strobe;
        check("points", 6'h05, current_point_outputs);
        // Every type in both modes, every point count
        for (i = 0; i < 16; i = i + 1) begin
            control_mode_select = i[3];
            point_count_select = i[1:0];
            home(i[2:0], i[3] & idx_types[i[2:0]]);
        end
        control_mode_select = 1'h0;
        // Stop, servo off, trip and alarm during a run
        for (i = 0; i < 4; i = i + 1) begin
            u_host.press(6'h3F);
            ab = 4'h1 << i;
            @(negedge clk);
            ab = 4'h0;
            ev = 4'h2;
            @(negedge clk);
            ev = 4'h0;
            check("complete", 1'h0, homing_complete_reg);
            u_host.release_strobe;
        end
        // Alarm, then tuning, after a good homing
        for (i = 0; i < 2; i = i + 1) begin
            home(3'h1, 1'h0);
            ab = i ? 4'h0 : 4'h8;
            ev = i ? 4'h8 : 4'h0;
            @(negedge clk);
            ab = 4'h0;
            ev = 4'h0;
            @(negedge clk);
            check("complete", 1'h0, homing_complete_reg);
        end
        // Each zero speed or ramp refuses homing
        for (i = 0; i < 4; i = i + 1) begin
            homing_speed_fast = (i == 0) ? 13'h0000 : 13'h0064;
            homing_speed_slow = (i == 1) ? 13'h0000 : 13'h0010;
            homing_accel_setting = (i == 2) ? 12'h000 : 12'h100;
            homing_decel_setting = (i == 3) ? 12'h000 : 12'h100;
            home(3'h1, 1'h1);
        end
        homing_decel_setting = 12'h100;
        // Power-on completion under absolute settings
        abs_encoder_present = 1'h1;
        for (i = 0; i < 3; i = i + 1) begin
            absolute_encoder_setting = i[1:0];
            do_reset;
            check("complete", i != 1, homing_complete_reg);
        end
        ab = 4'h8;
        @(negedge clk);
        ab = 4'h0;
        @(negedge clk);
        check("complete", 1'h1, homing_complete_reg);
        home(3'h6, 1'h0);
        check("nvm", abs_position, nvm_data_reg);
        // Power-on completion by homing skip
        abs_encoder_present = 1'h0;
        homing_skip_setting = 1'h1;
        home_offset_value = 32'h0000_4321;
        do_reset;
        check("complete", 1'h1, homing_complete_reg);
        check("preset", home_offset_value,
            position_preset_value_reg);
        report_and_stop;
    end
endmodule
